// >>> inc/ampc_pkg.sv
// Constants, types and encodings of the converter mode and power-on-reset controller.
// Assumes the decimation clock is the core clock and the serial clock is a separate domain.

package ampc_pkg;

    // ************************************************************
    // mode field encodings
    // ************************************************************
    localparam logic [1:0] MODE_SHDN = 2'h0;
    localparam logic [1:0] MODE_STBY = 2'h2;
    localparam logic [1:0] MODE_CONV = 2'h3;

    // ************************************************************
    // serial command byte: opcode in the upper nibble
    // ************************************************************
    localparam int         OP_HI     = 7;
    localparam int         OP_LO     = 4;
    localparam logic [3:0] OP_WRITE  = 4'h1;
    localparam logic [3:0] OP_CONV   = 4'h2;
    localparam logic [3:0] OP_STBY   = 4'h3;
    localparam logic [3:0] OP_SHDN   = 4'h4;
    localparam logic [3:0] OP_FULL   = 4'h5;
    localparam logic [2:0] BIT_LAST  = 3'h7;

    // ************************************************************
    // timing counts, in decimation clock periods
    // ************************************************************
    localparam logic [8:0] STARTUP_CYCLES = 9'h100;
    localparam logic [8:0] WAKE_ONE       = 9'h001;
    localparam logic [1:0] SYNC_CYCLES    = 2'h2;
    localparam logic [3:0] CONV_LAST      = 4'hF;
    localparam logic [1:0] STEP_LAST      = 2'h3;
    localparam logic [7:0] GAP_ONE        = 8'h01;

    // ************************************************************
    // actual converter state, gray coded along shdn-wake-stby-conv-gap
    // ************************************************************
    typedef enum logic [2:0] {
        ST_SHDN = 3'h0,
        ST_WAKE = 3'h1,
        ST_STBY = 3'h3,
        ST_CONV = 3'h2,
        ST_GAP  = 3'h6
    } ampc_state_t;

    typedef struct packed {
        logic [2:0]  bit_cnt;
        logic [6:0]  shreg;
    } ampc_shift_t;

    typedef struct packed {
        logic        tgl;
        logic [7:0]  data;
    } ampc_hand_t;

    typedef struct packed {
        logic        cs_s1;
        logic        cs_s2;
        logic        cs_s3;
        logic        tg_s1;
        logic        tg_s2;
        logic        tg_s3;
        logic        cs_seen;
        logic [1:0]  mode_field;
        ampc_state_t st;
        logic [8:0]  wake_cnt;
        logic [1:0]  hold;
        logic [3:0]  conv_cnt;
        logic [1:0]  step;
        logic [7:0]  gap_cnt;
        logic [15:0] result;
        logic        por_pend;
        logic        dr_pend;
        logic        dr_pulse;
        logic        start_pulse;
    } ampc_core_t;

endpackage : ampc_pkg

// >>> hdl/ampc_top.sv
// Converter operating-mode controller with power-on-reset handling.
// Assumes sample_in is valid in the decimation clock domain and that serial
// commands are spaced by at least four core clocks.
`timescale 1ns/100ps

module ampc_top
    import ampc_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    input  wire logic        avdd_good_in,
    input  wire logic        dvdd_good_in,
    input  wire logic        full_shutdown_in,
    input  wire logic        sck_in,
    input  wire logic        cs_n_in,
    input  wire logic        mosi_in,
    input  wire logic        scan_mode_in,
    input  wire logic        start_pulse_enable_in,
    input  wire logic [7:0]  scan_delay_in,
    input  wire logic [15:0] sample_in,
    output logic             spi_enable_out,
    output logic [1:0]       mode_field_out,
    output logic [2:0]       actual_state_out,
    output logic [8:0]       startup_count_out,
    output logic [1:0]       scan_step_out,
    output logic [15:0]      result_register_out,
    output logic             data_ready_out,
    output logic             conv_start_out,
    output logic             irq_n_out
);
    import ampc_pkg::*;

    // ************************************************************
    // power-on reset
    // ************************************************************
    logic        por_raw;
    logic [1:0]  por_sync;
    logic        por;
    // monitors are off in full shutdown, so their levels are not trusted
    assign por_raw = rst_in | (~full_shutdown_in & ~(avdd_good_in & dvdd_good_in));
    assign spi_enable_out = ~por_raw;

    // enters at once, leaves on a core edge so no flop sees a release mid-setup
    always_ff @(posedge ref_clk_in or posedge por_raw) begin
        if (por_raw) begin
            por_sync <= 2'h3;
        end else begin
            por_sync <= {por_sync[0], 1'b0};
        end
    end
    assign por = por_sync[1];

    // ************************************************************
    // serial clock domain
    // ************************************************************
    ampc_shift_t sh;
    ampc_shift_t next_sh;
    ampc_hand_t  hd;
    ampc_hand_t  next_hd;
    logic        sh_rst;

    // chip select high resets the shifter; the hand-off word must survive it
    assign sh_rst = por | cs_n_in;

    always_comb begin
        next_sh = sh;
        next_hd = hd;
        next_sh.bit_cnt = sh.bit_cnt + 3'h1;
        next_sh.shreg   = {sh.shreg[5:0], mosi_in};
        if (sh.bit_cnt == BIT_LAST) begin
            next_hd.data = {sh.shreg, mosi_in};
            next_hd.tgl  = ~hd.tgl;
        end
    end

    always_ff @(posedge sck_in or posedge sh_rst) begin
        if (sh_rst) begin
            sh <= '0;
        end else begin
            sh <= next_sh;
        end
    end

    always_ff @(posedge sck_in or posedge por) begin
        if (por) begin
            hd <= '0;
        end else begin
            hd <= next_hd;
        end
    end

    // ************************************************************
    // command decode in the core domain
    // ************************************************************
    ampc_core_t r;
    ampc_core_t next_r;
    logic       cmd_valid;
    logic [3:0] op;
    logic       wr;
    logic [1:0] wval;
    logic       fr_cmd;
    logic       cs_fall;

    // hd.data is stable well before its toggle is seen after two flops
    assign cmd_valid = (r.tg_s2 ^ r.tg_s3) & r.cs_seen;
    assign op        = hd.data[OP_HI:OP_LO];
    assign fr_cmd    = cmd_valid & (op == OP_FULL);
    assign cs_fall   = r.cs_s3 & ~r.cs_s2;

    always_comb begin
        wr   = 1'b0;
        wval = MODE_SHDN;
        if (cmd_valid) begin
            if (op == OP_WRITE) begin
                wr   = 1'b1;
                wval = hd.data[1:0];
            end else if (op == OP_CONV) begin
                wr   = 1'b1;
                wval = MODE_CONV;
            end else if (op == OP_STBY) begin
                wr   = 1'b1;
                wval = MODE_STBY;
            end else if (op == OP_SHDN) begin
                wr   = 1'b1;
                wval = MODE_SHDN;
            end
        end
    end

    // ************************************************************
    // core state machine
    // ************************************************************
    localparam ampc_core_t CORE_RST = '{
        cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1,
        tg_s1: 1'b0, tg_s2: 1'b0, tg_s3: 1'b0,
        cs_seen: 1'b0, mode_field: MODE_SHDN, st: ST_SHDN,
        wake_cnt: STARTUP_CYCLES, hold: 2'h0, conv_cnt: 4'h0,
        step: 2'h0, gap_cnt: 8'h00, result: 16'h0000,
        por_pend: 1'b1, dr_pend: 1'b0, dr_pulse: 1'b0, start_pulse: 1'b0
    };

    always_comb begin
        next_r = r;
        next_r.dr_pulse    = 1'b0;
        next_r.start_pulse = 1'b0;
        next_r.cs_s1 = cs_n_in;
        next_r.cs_s2 = r.cs_s1;
        next_r.cs_s3 = r.cs_s2;
        next_r.tg_s1 = hd.tgl;
        next_r.tg_s2 = r.tg_s1;
        next_r.tg_s3 = r.tg_s2;
        if (r.cs_s2) begin
            next_r.cs_seen = 1'b1;
        end
        if (cs_fall) begin
            next_r.por_pend = 1'b0;
            next_r.dr_pend  = 1'b0;
        end
        if (wr) begin
            next_r.mode_field = wval;
        end
        case (r.st)
            ST_SHDN: begin
                if (next_r.mode_field[1]) begin
                    next_r.st   = ST_WAKE;
                    next_r.hold = SYNC_CYCLES;
                end
            end
            ST_WAKE: begin
                if (!next_r.mode_field[1]) begin
                    next_r.st       = ST_SHDN;
                    next_r.wake_cnt = STARTUP_CYCLES;
                end else if (wr) begin
                    next_r.hold = SYNC_CYCLES;
                end else if (r.hold != 2'h0) begin
                    next_r.hold = r.hold - 2'h1;
                end else if (r.wake_cnt > WAKE_ONE) begin
                    next_r.wake_cnt = r.wake_cnt - WAKE_ONE;
                end else begin
                    next_r.wake_cnt = 9'h000;
                    if (next_r.mode_field == MODE_CONV) begin
                        next_r.st          = ST_CONV;
                        next_r.conv_cnt    = 4'h0;
                        next_r.start_pulse = start_pulse_enable_in;
                    end else begin
                        next_r.st = ST_STBY;
                    end
                end
            end
            ST_STBY: begin
                // converter held in reset here, counter already at zero
                if (!next_r.mode_field[1]) begin
                    next_r.st       = ST_SHDN;
                    next_r.wake_cnt = STARTUP_CYCLES;
                end else if (next_r.mode_field == MODE_CONV) begin
                    next_r.st          = ST_CONV;
                    next_r.conv_cnt    = 4'h0;
                    next_r.step        = 2'h0;
                    next_r.start_pulse = start_pulse_enable_in;
                end
            end
            ST_CONV: begin
                if (!next_r.mode_field[1]) begin
                    next_r.st       = ST_SHDN;
                    next_r.wake_cnt = STARTUP_CYCLES;
                end else if (next_r.mode_field == MODE_STBY) begin
                    next_r.st = ST_STBY;  // partial result dropped
                end else if (wr) begin
                    next_r.conv_cnt    = 4'h0;
                    next_r.step        = 2'h0;
                    next_r.start_pulse = start_pulse_enable_in;
                end else if (r.conv_cnt != CONV_LAST) begin
                    next_r.conv_cnt = r.conv_cnt + 4'h1;
                end else begin
                    next_r.result   = sample_in;
                    next_r.dr_pulse = 1'b1;
                    next_r.dr_pend  = 1'b1;
                    next_r.conv_cnt = 4'h0;
                    if (scan_mode_in && r.step == STEP_LAST && scan_delay_in != 8'h00) begin
                        // field keeps 11; only the converter drops to shutdown
                        next_r.st       = ST_GAP;
                        next_r.wake_cnt = STARTUP_CYCLES;
                        next_r.gap_cnt  = scan_delay_in;
                        next_r.step     = 2'h0;
                    end else begin
                        next_r.step        = scan_mode_in ? r.step + 2'h1 : 2'h0;
                        next_r.start_pulse = start_pulse_enable_in;
                    end
                end
            end
            ST_GAP: begin
                if (!next_r.mode_field[1]) begin
                    next_r.st = ST_SHDN;
                end else if (wr) begin
                    next_r.st   = ST_WAKE;
                    next_r.hold = SYNC_CYCLES;
                    next_r.step = 2'h0;
                end else if (r.gap_cnt <= GAP_ONE) begin
                    // internal transition: no serial sync delay
                    next_r.st   = ST_WAKE;
                    next_r.hold = 2'h0;
                end else begin
                    next_r.gap_cnt = r.gap_cnt - GAP_ONE;
                end
            end
            default: begin
                next_r.st       = ST_SHDN;
                next_r.wake_cnt = STARTUP_CYCLES;
            end
        endcase
        if (fr_cmd) begin
            next_r.mode_field  = MODE_SHDN;
            next_r.st          = ST_SHDN;
            next_r.wake_cnt    = STARTUP_CYCLES;
            next_r.hold        = 2'h0;
            next_r.conv_cnt    = 4'h0;
            next_r.step        = 2'h0;
            next_r.gap_cnt     = 8'h00;
            next_r.result      = 16'h0000;
            next_r.dr_pend     = 1'b0;
            next_r.dr_pulse    = 1'b0;
            next_r.start_pulse = 1'b0;
        end
        if (!ce_in) begin
            next_r = r;
        end
    end

    always_ff @(posedge ref_clk_in or posedge por) begin
        if (por) begin
            r <= CORE_RST;
        end else begin
            r <= next_r;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign mode_field_out      = r.mode_field;
    assign actual_state_out    = r.st;
    assign startup_count_out   = r.wake_cnt;
    assign scan_step_out       = r.step;
    assign result_register_out = r.result;
    assign data_ready_out      = r.dr_pulse;
    assign conv_start_out      = r.start_pulse;
    assign irq_n_out           = ~(r.por_pend | r.dr_pend);

    // ************************************************************
    // checks
    // ************************************************************
    localparam int STARTUP_MIN = 256;
    logic [9:0] wake_len;
    always_ff @(posedge ref_clk_in or posedge por) begin
        if (por) begin
            wake_len <= 10'h000;
        end else if (ce_in) begin
            wake_len <= (r.st == ST_WAKE) ? wake_len + 10'h001 : 10'h000;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (por);

    chk_shdn_immediate: assert property (
        (r.st != ST_SHDN && wr && !wval[1] && ce_in && !fr_cmd) |=> r.st == ST_SHDN
    ) else $error("shutdown not immediate");

    chk_reload_count: assert property (
        (r.st == ST_SHDN || r.st == ST_GAP) |-> r.wake_cnt == STARTUP_CYCLES
    ) else $error("start-up count not reloaded in shutdown");

    chk_startup_length: assert property (
        (r.st == ST_CONV && $past(r.st) == ST_WAKE) |-> wake_len >= STARTUP_MIN
    ) else $error("conversion started before full start-up interval");

    chk_sync_wait: assert property (
        (r.st == ST_SHDN && wr && wval[1] && ce_in && !fr_cmd)
        |=> r.st == ST_WAKE ##1 r.wake_cnt == STARTUP_CYCLES ##1 r.wake_cnt == STARTUP_CYCLES
    ) else $error("start-up count moved during sync delay");

    chk_stby_start: assert property (
        (r.st == ST_STBY && wr && wval == MODE_CONV && ce_in && !fr_cmd)
        |=> r.st == ST_CONV && r.conv_cnt == 4'h0
    ) else $error("standby to conversion not immediate");

    chk_conv_restart: assert property (
        (r.st == ST_CONV && wr && wval == MODE_CONV && ce_in && !fr_cmd)
        |=> r.conv_cnt == 4'h0 && r.start_pulse == $past(start_pulse_enable_in)
    ) else $error("rewrite did not restart conversion");

    chk_scan_restart: assert property (
        (scan_mode_in && r.st == ST_CONV && wr && wval == MODE_CONV && ce_in && !fr_cmd)
        |=> r.step == 2'h0
    ) else $error("scan rewrite did not return to first step");

    chk_gap_rewrite: assert property (
        (r.st == ST_GAP && wr && wval == MODE_CONV && ce_in && !fr_cmd)
        |=> r.st == ST_WAKE && r.wake_cnt == STARTUP_CYCLES && r.hold == SYNC_CYCLES
    ) else $error("gap rewrite skipped start-up interval");

    chk_field_scan: assert property (
        (r.st == ST_GAP) |-> r.mode_field == MODE_CONV
    ) else $error("mode field not 11 during scan gap");

    chk_result_load: assert property (
        $changed(r.result) |-> (r.dr_pulse || $past(fr_cmd))
    ) else $error("result changed without a completed conversion");

    chk_ready_irq: assert property (
        r.dr_pulse |-> !irq_n_out
    ) else $error("data ready not on interrupt pin");

    chk_por_clear: assert property (
        (cs_fall && ce_in) |=> !r.por_pend
    ) else $error("chip select fall did not clear power-on interrupt");

    chk_wake_count: assert property (
        (r.st == ST_WAKE && r.mode_field[1] && !wr && r.hold == 2'h0 && r.wake_cnt > WAKE_ONE
         && ce_in && !fr_cmd) |=> r.wake_cnt == $past(r.wake_cnt) - WAKE_ONE
    ) else $error("start-up count did not step down");

    chk_conv_length: assert property (
        (r.dr_pulse && $past(ce_in)) |-> $past(r.conv_cnt) == CONV_LAST
    ) else $error("result loaded before conversion end");

    cov_conversion: cover property (r.dr_pulse);
    cov_scan_gap: cover property (r.st == ST_CONV ##1 r.st == ST_GAP);
    cov_restart: cover property (r.st == ST_CONV && wr && wval == MODE_CONV);
    cov_por_cleared: cover property (r.por_pend ##1 !r.por_pend);
    cov_stby_conv: cover property (r.st == ST_STBY ##1 r.st == ST_CONV);

endmodule : ampc_top

// >>> verif/ampc_host.sv
// Serial host model: one command byte per chip-select frame, msb first.
// Assumes the caller spaces frames; the link clock idles low between frames.
`timescale 1ns/100ps

module ampc_host (
    output logic cs_n_out,
    output logic sck_out,
    output logic mosi_out
);
    // ******************************
    // frame driver, 12 ns link clock
    // ******************************
    initial begin
        cs_n_out = 1'b1;
        sck_out  = 1'b0;
        mosi_out = 1'b0;
    end

    // high pulse opens every frame, so a low chip select in reset is left
    task automatic send(input logic [7:0] b);
        cs_n_out = 1'b1;
        #24;
        cs_n_out = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            mosi_out = b[i];
            #6;
            sck_out = 1'b1;
            #6;
            sck_out = 1'b0;
        end
        #6;
        cs_n_out = 1'b1;
        // released data line shows the inverse, never a stale bit
        mosi_out = ~mosi_out;
    endtask : send
endmodule : ampc_host

// >>> verif/ampc_top_test.sv
// Self-checking bench of the converter mode and power-on-reset controller.
// Assumes the host model owns the serial pins; other inputs change on falling edges.
`timescale 1ns/100ps

module ampc_top_test;
    import ampc_pkg::*;

    logic        ref_clk_in            = 1'b0;
    logic        rst_in                = 1'b1;
    logic        ce_in                 = 1'b1;
    logic        avdd_good_in          = 1'b1;
    logic        dvdd_good_in          = 1'b1;
    logic        full_shutdown_in      = 1'b0;
    logic        scan_mode_in          = 1'b0;
    logic        start_pulse_enable_in = 1'b1;
    logic [7:0]  scan_delay_in         = 8'h00;
    logic [15:0] sample_in             = 16'h0000;
    logic        cs_n, sck, mosi, spi_en, dr, cst, irq_n;
    logic [1:0]  mode, step;
    logic [2:0]  st;
    logic [8:0]  cnt;
    logic [15:0] res;
    logic [15:0] exp_res;
    int          error_cnt             = 0;
    int          num_checks            = 0;
    int          seed                  = 32'h3c343ce4;
    int          n;

    always #5 ref_clk_in = ~ref_clk_in;

    ampc_host host (.cs_n_out(cs_n), .sck_out(sck), .mosi_out(mosi));

    ampc_top dut (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .avdd_good_in(avdd_good_in), .dvdd_good_in(dvdd_good_in),
        .full_shutdown_in(full_shutdown_in), .sck_in(sck), .cs_n_in(cs_n),
        .mosi_in(mosi), .scan_mode_in(scan_mode_in),
        .start_pulse_enable_in(start_pulse_enable_in), .scan_delay_in(scan_delay_in),
        .sample_in(sample_in), .spi_enable_out(spi_en), .mode_field_out(mode),
        .actual_state_out(st), .startup_count_out(cnt), .scan_step_out(step),
        .result_register_out(res), .data_ready_out(dr), .conv_start_out(cst),
        .irq_n_out(irq_n)
    );

    // ******************************
    // helpers
    // ******************************
    function automatic ampc_state_t exp_state(input logic [1:0] f);
        return (f == MODE_CONV) ? ST_CONV : ((f == MODE_STBY) ? ST_STBY : ST_SHDN);
    endfunction : exp_state

    task automatic results();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(negedge ref_clk_in);
    endtask : cyc

    // bounded wait: 0 start pulse, 1 data ready, 2 mode field, 3 actual state
    task automatic wait_for(input int k, input logic [2:0] v, input int lim);
        logic hit;
        n = 0;
        hit = 1'b0;
        while (!hit) begin
            @(negedge ref_clk_in);
            n++;
            case (k)
                0: hit = (cst === 1'b1);
                1: hit = (dr === 1'b1);
                2: hit = (mode === v[1:0]);
                default: hit = (st === v);
            endcase
            if (!hit && n >= lim) begin
                chk("wait", 16'h0000, 16'h0001);
                results();
            end
        end
    endtask : wait_for

    // ******************************
    // scenarios
    // ******************************
    initial begin
        cyc(16);
        rst_in = 1'b0;
        for (int i = 0; i < 8; i++) begin
            {full_shutdown_in, avdd_good_in, dvdd_good_in} = i[2:0];
            #1;
            chk("spi_en", i[2] | (i[1] & i[0]), spi_en);
            cyc(1);
        end
        {full_shutdown_in, avdd_good_in, dvdd_good_in} = 3'h3;
        cyc(2);
        chk("mode", MODE_SHDN, mode);
        chk("state", ST_SHDN, st);
        chk("count", STARTUP_CYCLES, cnt);
        chk("result", 16'h0000, res);
        chk("irq_n", 16'h0000, irq_n);
        dvdd_good_in = 1'b0;
        host.send({OP_WRITE, 2'b00, MODE_CONV});
        cyc(1);
        dvdd_good_in = 1'b1;
        cyc(6);
        chk("mode", MODE_SHDN, mode);
        chk("irq_n", 16'h0000, irq_n);
        exp_res = 16'($random(seed));
        sample_in = exp_res;
        host.send({OP_WRITE, 2'b00, MODE_CONV});
        wait_for(2, MODE_CONV, 20);
        chk("state", ST_WAKE, st);
        chk("count", STARTUP_CYCLES, cnt);
        chk("irq_n", 16'h0001, irq_n);
        wait_for(0, 3'h0, 300);
        chk("startup", 16'h0001, n >= 256 && n <= 260);
        chk("state", ST_CONV, st);
        wait_for(1, 3'h0, 20);
        chk("result", exp_res, res);
        cyc(1);
        chk("irq_n", 16'h0000, irq_n);
        cyc(7);
        exp_res = 16'($random(seed));
        sample_in = exp_res;
        host.send({OP_WRITE, 2'b00, MODE_CONV});
        wait_for(0, 3'h0, 8);
        wait_for(1, 3'h0, 20);
        chk("restart", 16'h0001, n >= 14);
        chk("result", exp_res, res);
        host.send({OP_STBY, 4'h0});
        wait_for(2, MODE_STBY, 20);
        cyc(2);
        chk("state", ST_STBY, st);
        host.send({OP_CONV, 4'h0});
        wait_for(2, MODE_CONV, 20);
        // start pulse stands one cycle, on the edge of the field update
        chk("no_wait", 16'h0001, cst);
        chk("state", ST_CONV, st);
        host.send({OP_SHDN, 4'h0});
        wait_for(2, MODE_SHDN, 20);
        chk("state", ST_SHDN, st);
        chk("count", STARTUP_CYCLES, cnt);
        chk("result", exp_res, res);
        for (int f = 0; f < 4; f++) begin
            host.send({OP_WRITE, 2'b00, f[1:0]});
            wait_for(2, {1'b0, f[1:0]}, 20);
            cyc(f[1] ? 270 : 2);
            chk("state", exp_state(f[1:0]), st);
        end
        // clock enable low: a conversion end must not load the new sample
        ce_in = 1'b0;
        sample_in = 16'($random(seed));
        cyc(20);
        chk("frozen", exp_res, res);
        chk("state", ST_CONV, st);
        exp_res = sample_in;
        ce_in = 1'b1;
        wait_for(1, 3'h0, 20);
        chk("result", exp_res, res);
        host.send({OP_FULL, 4'h0});
        cyc(8);
        chk("result", 16'h0000, res);
        chk("mode", MODE_SHDN, mode);
        scan_mode_in = 1'b1;
        scan_delay_in = 8'hFF;
        host.send({OP_WRITE, 2'b00, MODE_CONV});
        wait_for(0, 3'h0, 300);
        wait_for(3, ST_GAP, 200);
        chk("mode", MODE_CONV, mode);
        host.send({OP_WRITE, 2'b00, MODE_CONV});
        wait_for(3, ST_WAKE, 30);
        chk("count", STARTUP_CYCLES, cnt);
        chk("step", 16'h0000, step);
        chk("mode", MODE_CONV, mode);
        wait_for(0, 3'h0, 300);
        chk("startup", 16'h0001, n >= 256 && n <= 260);
        results();
    end
endmodule : ampc_top_test
